// ==== core/pmt_pkg.sv ====
// program memory table read block: shared constants and types
// assumes one core clock for the core side and a programmer-driven link clock
//
// Contract
// - program store holds 2048 words of 16 bits, fetched at the program counter.
// - after any reset the first fetch is from word address zero.
// - table data may sit anywhere, reached by a pointer separate from the counter.
// - table read address is formed from low and high pointer bytes together.
// - low byte of the addressed word goes to the operand data location.
// - upper byte of the same word goes into the upper byte latch.
// - unimplemented upper byte bits read back as zero in the latch.
// - upper byte latch is read only; only table reads change it.
// - every table instruction takes exactly two instruction cycles.
// - paged table read uses the full address from both pointer bytes; the code uses only the low pointer byte, inside the page at 700 hex.
// - the last 256-word page starts at word address 700 hex.
// - programming moves data and address both ways on one serial pin, own clock.
// - debug data pin is two-way, debug clock is an input from the adapter.
// - while debugging, the other functions on the two debug pins have no effect.
// - debug pins still serve as the programming data and clock pins.
// - one instruction cycle is four phases, so two cycles span eight phases.
package pmt_pkg;

  // ----------------------------------------------------------------
  // program store
  // ----------------------------------------------------------------
  localparam int          ADDR_W         = 11;
  localparam int          WORD_W         = 16;
  localparam int          BYTE_W         = 8;
  localparam int          STORE_DEPTH    = 2048;
  localparam logic [10:0] RESET_VECTOR   = 11'h000;
  localparam logic [10:0] LAST_PAGE_BASE = 11'h700;
  localparam logic [7:0]  UPPER_MASK_DEF = 8'hff;

  // ----------------------------------------------------------------
  // instruction timing
  // ----------------------------------------------------------------
  localparam int PHASES_PER_INSTR = 4;
  localparam int TABLE_INSTR_CYC  = 2;
  localparam int TABLE_CLKS       = PHASES_PER_INSTR * TABLE_INSTR_CYC;
  localparam int TABLE_WAIT_CLKS  = TABLE_CLKS - 2;
  localparam logic [2:0] TABLE_WAIT_LAST = 3'(TABLE_WAIT_CLKS - 1);

  typedef enum logic [1:0] {
    PH_T1 = 2'b00,
    PH_T2 = 2'b01,
    PH_T3 = 2'b11,
    PH_T4 = 2'b10
  } pmt_phase_e;

  typedef enum logic [1:0] {
    TR_IDLE = 2'b00,
    TR_READ = 2'b01,
    TR_WAIT = 2'b11,
    TR_DONE = 2'b10
  } pmt_table_e;

  // ----------------------------------------------------------------
  // serial programming frame: cmd, address, turnaround, data
  // ----------------------------------------------------------------
  localparam logic [4:0] FRM_HDR_LAST  = 5'h0b;
  localparam logic [4:0] FRM_TURN_LAST = 5'h0f;
  localparam logic [4:0] FRM_LAST      = 5'h1f;

endpackage

// ==== core/pmt_sync2.sv ====
// two flip-flop level synchroniser
// assumes d is a level from another domain or a pin
module pmt_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  logic [W-1:0] meta_reg;

  // meta_reg feeds q and nothing else
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end

endmodule

// ==== core/pmt_prog_store.sv ====
// program store: two registered read ports and one write port
// assumes all ports run on one clock; read data lag the address by one edge
module pmt_prog_store #(
  parameter int ADDR_W = 11,
  parameter int WORD_W = 16
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic [ADDR_W-1:0] rd_a_addr,
  output logic      [WORD_W-1:0] rd_a_data,
  input  wire logic [ADDR_W-1:0] rd_b_addr,
  output logic      [WORD_W-1:0] rd_b_data,
  input  wire logic              wr_en,
  input  wire logic [ADDR_W-1:0] wr_addr,
  input  wire logic [WORD_W-1:0] wr_data
);

  logic [WORD_W-1:0] mem [2**ADDR_W];

  always_ff @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rd_a_data <= '0;
      rd_b_data <= '0;
    end else begin
      rd_a_data <= mem[rd_a_addr];
      rd_b_data <= mem[rd_b_addr];
    end
  end

endmodule

// ==== core/pmt_table_read.sv ====
// program memory access: fetch, table reads, serial programming/debug link
// assumes the core presents pc_next by the last phase of each instruction cycle
// and holds table requests until it sees table_busy; link clock comes from the tool
module pmt_table_read
  import pmt_pkg::*;
#(
  parameter logic [7:0] UPPER_MASK = UPPER_MASK_DEF
) (
  input  wire logic              ref_clk,
  input  wire logic              reset_n,
  // core side
  input  wire logic [ADDR_W-1:0] pc_next,
  output logic      [ADDR_W-1:0] fetch_addr,
  output logic      [WORD_W-1:0] fetch_word,
  output logic      [1:0]        instr_phase,
  input  wire logic              ptr_lo_wr,
  input  wire logic              ptr_hi_wr,
  input  wire logic [BYTE_W-1:0] ptr_wdata,
  input  wire logic              table_req,
  input  wire logic              table_last_page,
  input  wire logic [BYTE_W-1:0] table_dest,
  output logic                   table_busy,
  output logic                   dm_wr_en,
  output logic      [BYTE_W-1:0] dm_wr_addr,
  output logic      [BYTE_W-1:0] dm_wr_data,
  output logic      [BYTE_W-1:0] table_upper_byte_latch,
  // shared pins and their general purpose functions
  input  wire logic              in_circuit_programming,
  input  wire logic              on_chip_debug,
  input  wire logic              prog_serial_clock,
  input  wire logic              prog_serial_data_i,
  output logic                   prog_serial_data_o,
  output logic                   prog_serial_data_oe,
  input  wire logic              gpio_a0_out,
  input  wire logic              gpio_a0_oe,
  input  wire logic              gpio_a2_out,
  input  wire logic              gpio_a2_oe,
  output logic                   gpio_a0_in,
  output logic                   gpio_a2_in,
  output logic                   port_a_bit_zero_o,
  output logic                   port_a_bit_zero_oe,
  output logic                   port_a_bit_two_o,
  output logic                   port_a_bit_two_oe
);

  initial begin
    if (ADDR_W != 11 || WORD_W != 2 * BYTE_W || STORE_DEPTH != 2 ** ADDR_W) begin
      $error("pmt_table_read: store geometry not supported");
    end
  end

  // ----------------------------------------------------------------
  // instruction phases and fetch
  // ----------------------------------------------------------------
  pmt_phase_e        phase_reg;
  pmt_phase_e        phase_next;
  logic              first_cycle_reg;
  logic [ADDR_W-1:0] fetch_addr_reg;
  logic              at_t1;
  logic              at_t4;

  assign at_t1 = (phase_reg == PH_T1);
  assign at_t4 = (phase_reg == PH_T4);

  always_comb begin
    unique case (phase_reg)
      PH_T1: phase_next = PH_T2;
      PH_T2: phase_next = PH_T3;
      PH_T3: phase_next = PH_T4;
      PH_T4: phase_next = PH_T1;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase_reg       <= PH_T1;
      first_cycle_reg <= 1'b1;
      fetch_addr_reg  <= RESET_VECTOR;
    end else begin
      phase_reg <= phase_next;
      if (at_t4) begin
        first_cycle_reg <= 1'b0;
        fetch_addr_reg  <= pc_next;
      end
    end
  end

  assign fetch_addr  = fetch_addr_reg;
  assign instr_phase = phase_reg;

  // ----------------------------------------------------------------
  // table pointer and table read sequencer
  // ----------------------------------------------------------------
  logic [BYTE_W-1:0] ptr_lo_reg;
  logic [2:0]        ptr_hi_reg;
  pmt_table_e        tr_state_reg;
  pmt_table_e        tr_state_next;
  logic [2:0]        tr_cnt_reg;
  logic [ADDR_W-1:0] tbl_addr_reg;
  logic [BYTE_W-1:0] dest_reg;
  logic [ADDR_W-1:0] tbl_addr_next;
  logic              tr_take;
  logic              tr_finish;
  logic [WORD_W-1:0] rd_b_data;
  logic [WORD_W-1:0] tbl_word_reg;

  // fetch reads store port a and table reads use port b, so no fetch stalls behind a read
  assign tbl_addr_next = table_last_page ? (LAST_PAGE_BASE | {3'h0, ptr_lo_reg})
                                         : {ptr_hi_reg, ptr_lo_reg};
  assign tr_take       = table_req && (tr_state_reg == TR_IDLE) && at_t1;
  assign tr_finish     = (tr_state_reg == TR_DONE);

  always_comb begin
    unique case (tr_state_reg)
      TR_IDLE: tr_state_next = tr_take ? TR_READ : TR_IDLE;
      TR_READ: tr_state_next = TR_WAIT;
      TR_WAIT: tr_state_next = (tr_cnt_reg == TABLE_WAIT_LAST) ? TR_DONE : TR_WAIT;
      TR_DONE: tr_state_next = TR_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      ptr_lo_reg <= '0;
      ptr_hi_reg <= '0;
    end else begin
      if (ptr_lo_wr) begin
        ptr_lo_reg <= ptr_wdata;
      end
      if (ptr_hi_wr) begin
        ptr_hi_reg <= ptr_wdata[2:0];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      tr_state_reg <= TR_IDLE;
      tr_cnt_reg   <= '0;
      tbl_addr_reg <= '0;
      dest_reg     <= '0;
      tbl_word_reg <= '0;
    end else begin
      tr_state_reg <= tr_state_next;
      tr_cnt_reg   <= (tr_state_reg == TR_WAIT) ? tr_cnt_reg + 3'h1 : 3'h0;
      if (tr_take) begin
        tbl_addr_reg <= tbl_addr_next;
        dest_reg     <= table_dest;
      end
      if (tr_state_reg == TR_WAIT && tr_cnt_reg == 3'h0) begin
        tbl_word_reg <= rd_b_data;
      end
    end
  end

  // latch has no software write path at all; only a finished read loads it
  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      table_busy             <= 1'b0;
      dm_wr_en               <= 1'b0;
      dm_wr_addr             <= '0;
      dm_wr_data             <= '0;
      table_upper_byte_latch <= '0;
    end else begin
      table_busy <= tr_take || (table_busy && !tr_finish);
      dm_wr_en   <= tr_finish;
      if (tr_finish) begin
        dm_wr_addr             <= dest_reg;
        dm_wr_data             <= tbl_word_reg[BYTE_W-1:0];
        table_upper_byte_latch <= tbl_word_reg[WORD_W-1:BYTE_W] & UPPER_MASK;
      end
    end
  end

  // ----------------------------------------------------------------
  // shared pin control
  // ----------------------------------------------------------------
  logic [3:0] pins_s;
  logic       link_on;

  pmt_sync2 #(.W(4)) u_pin_sync (
    .clk     (ref_clk),
    .reset_n (reset_n),
    .d       ({in_circuit_programming, on_chip_debug, prog_serial_data_i, prog_serial_clock}),
    .q       (pins_s)
  );

  // one link serves both tools, so debug reuses the programming pins
  assign link_on = pins_s[3] || pins_s[2];

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      port_a_bit_zero_o  <= 1'b0;
      port_a_bit_zero_oe <= 1'b0;
      port_a_bit_two_o   <= 1'b0;
      port_a_bit_two_oe  <= 1'b0;
      gpio_a0_in         <= 1'b0;
      gpio_a2_in         <= 1'b0;
    end else begin
      port_a_bit_zero_o  <= gpio_a0_out && !link_on;
      port_a_bit_zero_oe <= gpio_a0_oe && !link_on;
      port_a_bit_two_o   <= gpio_a2_out && !link_on;
      port_a_bit_two_oe  <= gpio_a2_oe && !link_on;
      gpio_a0_in         <= pins_s[1] && !link_on;
      gpio_a2_in         <= pins_s[0] && !link_on;
    end
  end

  // ----------------------------------------------------------------
  // link domain: serial frame on the tool's clock
  // ----------------------------------------------------------------
  logic              mode_l;
  logic [4:0]        bit_cnt_reg;
  logic [27:0]       shift_reg;
  logic              rd_cmd_reg;
  logic [ADDR_W-1:0] link_addr_reg;
  logic [WORD_W-1:0] link_wdata_reg;
  logic [WORD_W-1:0] out_shift_reg;
  logic              wr_tgl_reg;
  logic              rd_tgl_reg;
  logic [WORD_W-1:0] prog_rd_word_reg;
  logic              hdr_done;
  logic              frm_done;
  logic              link_arst_n;

  // a mode pin going low clears the link at once: the tool's clock stands still between frames,
  // so a synchroniser clocked by it would hold a stale mode and leave a cut frame half counted
  assign link_arst_n = reset_n && (in_circuit_programming || on_chip_debug);

  pmt_sync2 #(.W(1)) u_mode_sync_l (
    .clk     (prog_serial_clock),
    .reset_n (link_arst_n),
    .d       (1'b1),
    .q       (mode_l)
  );

  assign hdr_done = (bit_cnt_reg == FRM_HDR_LAST);
  assign frm_done = (bit_cnt_reg == FRM_LAST);

  always_ff @(posedge prog_serial_clock or negedge mode_l) begin
    if (!mode_l) begin
      bit_cnt_reg <= '0;
      shift_reg   <= '0;
    end else begin
      bit_cnt_reg <= bit_cnt_reg + 5'h1;
      shift_reg   <= {shift_reg[26:0], prog_serial_data_i};
    end
  end

  always_ff @(posedge prog_serial_clock or negedge reset_n) begin
    if (!reset_n) begin
      rd_cmd_reg     <= 1'b0;
      link_addr_reg  <= '0;
      link_wdata_reg <= '0;
      wr_tgl_reg     <= 1'b0;
      rd_tgl_reg     <= 1'b0;
    end else if (mode_l) begin
      if (hdr_done) begin
        rd_cmd_reg    <= shift_reg[ADDR_W-1];
        link_addr_reg <= {shift_reg[ADDR_W-2:0], prog_serial_data_i};
        rd_tgl_reg    <= rd_tgl_reg ^ shift_reg[ADDR_W-1];
      end
      if (frm_done && !rd_cmd_reg) begin
        link_wdata_reg <= {shift_reg[WORD_W-2:0], prog_serial_data_i};
        wr_tgl_reg     <= !wr_tgl_reg;
      end
    end
  end

  // read word is parked by the core side long before the turnaround ends;
  // all sixteen bits leave on edges 15..30 so the pin is free again at edge 31
  always_ff @(posedge prog_serial_clock or negedge mode_l) begin
    if (!mode_l) begin
      out_shift_reg       <= '0;
      prog_serial_data_o  <= 1'b0;
      prog_serial_data_oe <= 1'b0;
    end else begin
      if (bit_cnt_reg == FRM_TURN_LAST - 5'h1) begin
        out_shift_reg <= prog_rd_word_reg;
      end else begin
        out_shift_reg <= {out_shift_reg[WORD_W-2:0], 1'b0};
      end
      prog_serial_data_o  <= out_shift_reg[WORD_W-1];
      prog_serial_data_oe <= rd_cmd_reg && (bit_cnt_reg >= FRM_TURN_LAST) && !frm_done;
    end
  end

  // ----------------------------------------------------------------
  // crossing back to the core clock and store arbitration
  // ----------------------------------------------------------------
  logic              wr_tgl_s;
  logic              rd_tgl_s;
  logic              wr_tgl_seen_reg;
  logic              rd_tgl_seen_reg;
  logic              prog_rd_pend_reg;
  logic              prog_rd_slot_reg;
  logic              prog_wr;
  logic              prog_rd_go;
  logic [ADDR_W-1:0] rd_b_addr;
  logic [ADDR_W-1:0] link_addr_s;

  pmt_sync2 #(.W(2)) u_tgl_sync (
    .clk     (ref_clk),
    .reset_n (reset_n),
    .d       ({wr_tgl_reg, rd_tgl_reg}),
    .q       ({wr_tgl_s, rd_tgl_s})
  );

  // address and write word are held by the link side across the toggle
  assign link_addr_s = link_addr_reg;
  assign prog_wr     = wr_tgl_s ^ wr_tgl_seen_reg;
  // a table read owns port b in its read cycle; the programmer waits one edge
  assign prog_rd_go  = prog_rd_pend_reg && (tr_state_reg != TR_READ);
  assign rd_b_addr   = (tr_state_reg == TR_READ) ? tbl_addr_reg : link_addr_s;

  always_ff @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_tgl_seen_reg  <= 1'b0;
      rd_tgl_seen_reg  <= 1'b0;
      prog_rd_pend_reg <= 1'b0;
      prog_rd_slot_reg <= 1'b0;
      prog_rd_word_reg <= '0;
    end else begin
      wr_tgl_seen_reg  <= wr_tgl_s;
      rd_tgl_seen_reg  <= rd_tgl_s;
      prog_rd_pend_reg <= (rd_tgl_s ^ rd_tgl_seen_reg) || (prog_rd_pend_reg && !prog_rd_go);
      prog_rd_slot_reg <= prog_rd_go;
      if (prog_rd_slot_reg) begin
        prog_rd_word_reg <= rd_b_data;
      end
    end
  end

  pmt_prog_store #(.ADDR_W(ADDR_W), .WORD_W(WORD_W)) u_store (
    .clk       (ref_clk),
    .reset_n   (reset_n),
    .rd_a_addr (fetch_addr_reg),
    .rd_a_data (fetch_word),
    .rd_b_addr (rd_b_addr),
    .rd_b_data (rd_b_data),
    .wr_en     (prog_wr),
    .wr_addr   (link_addr_s),
    .wr_data   (link_wdata_reg)
  );

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  table_len_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    tr_take |-> ##1 (!dm_wr_en) [*8] ##1 dm_wr_en)
    else $error("table read did not finish in eight clocks");

  table_pulse_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    dm_wr_en |=> !dm_wr_en)
    else $error("data write longer than one clock");

  full_addr_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    tr_take && !table_last_page |=> tbl_addr_reg == {$past(ptr_hi_reg), $past(ptr_lo_reg)})
    else $error("table address not taken from both pointers");

  last_page_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    tr_take && table_last_page |=> tbl_addr_reg[10:8] == 3'h7 && tbl_addr_reg[7:0] == $past(ptr_lo_reg))
    else $error("last page address wrong");

  latch_only_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    $changed(table_upper_byte_latch) |-> $past(tr_state_reg) == TR_DONE)
    else $error("upper latch changed without table read");

  latch_mask_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (table_upper_byte_latch & ~UPPER_MASK) == 8'h00)
    else $error("unimplemented latch bit set");

  low_byte_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    tr_finish |=> dm_wr_data == $past(tbl_word_reg[7:0]) && dm_wr_addr == $past(dest_reg))
    else $error("low byte or destination wrong");

  reset_vec_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    first_cycle_reg |-> fetch_addr_reg == RESET_VECTOR)
    else $error("first fetch not at word zero");

  phase_walk_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    at_t1 |=> phase_reg == PH_T2 ##1 phase_reg == PH_T3 ##1 at_t4 ##1 at_t1)
    else $error("phase sequence broken");

  pin_quiet_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
    link_on |=> !port_a_bit_zero_oe && !port_a_bit_two_oe && !gpio_a0_in && !gpio_a2_in)
    else $error("shared pin function active during link");

  link_drive_a: assert property (@(posedge prog_serial_clock) disable iff (!reset_n)
    prog_serial_data_oe |-> $past(rd_cmd_reg) && $past(bit_cnt_reg) >= FRM_TURN_LAST)
    else $error("link pin driven outside read data");

  table_rd_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
    tr_take && !table_last_page ##9 dm_wr_en);
  last_rd_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
    tr_take && table_last_page);
  prog_wr_c: cover property (@(posedge ref_clk) disable iff (!reset_n)
    prog_wr);
  prog_rd_c: cover property (@(posedge prog_serial_clock) disable iff (!reset_n)
    prog_serial_data_oe);

endmodule

// ==== bench/pmt_tool_model.sv ====
// tool model: the programming or debug adapter on the far side of the link
// assumes the bench resolves the shared data wire from sd_en and the device enable
module pmt_tool_model (
  output logic      sclk,
  output logic      sd_en,
  output logic      sd_val,
  input  wire logic sd_pin,
  input  wire logic sd_oe
);
  timeunit 1ns;
  timeprecision 100ps;

  initial begin
    sclk = 1'b0;
    sd_en = 1'b0;
    sd_val = 1'b0;
  end

  // one frame of 32 bits, 64 ns clock that stands still between frames
  task automatic frame(input logic rd, input logic [10:0] a, input logic [15:0] wd, output logic [15:0] q);
    logic [31:0] bits;
    bits = {rd, a, 4'h0, wd};
    q = 16'h0000;
    // two idle clocks arm the device's link after the mode pin rises
    repeat (2) begin
      #16 sclk = 1'b1;
      #32 sclk = 1'b0;
      #16;
    end
    for (int i = 31; i >= 0; i--) begin
      sd_en = !(rd && i < 20);  // let go before the device turns the wire round
      sd_val = bits[i];
      #16 sclk = 1'b1;
      #32;
      if (sd_oe) q = {q[14:0], sd_pin};
      sclk = 1'b0;
      #16;
    end
    sd_en = 1'b0;
  endtask
endmodule

// ==== bench/pmt_table_read_tb.sv ====
// bench for the program memory table read block
// assumes the tool model drives the link; inputs change at falling edges
module pmt_table_read_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import pmt_pkg::*;
  localparam logic [7:0] MASK = 8'h3f;
  logic ref_clk = 1'b0, reset_n = 1'b0, ptr_lo_wr = 1'b0, ptr_hi_wr = 1'b0, table_req = 1'b0;
  logic table_last_page = 1'b0, in_circuit_programming = 1'b0, on_chip_debug = 1'b0;
  logic [10:0] pc_next = 11'h000, fetch_addr;
  logic [7:0] ptr_wdata = 8'h00, table_dest = 8'h00, dm_wr_addr, dm_wr_data, table_upper_byte_latch;
  logic [15:0] fetch_word, rq;
  logic [1:0] instr_phase;
  logic table_busy, dm_wr_en, sclk, sd_o, sd_oe, m_en, m_val, sd_pin, a0_in, a2_in, a0_o, a0_oe, a2_o, a2_oe;
  int fail_count = 0, n_checks = 0;
  assign sd_pin = sd_oe ? sd_o : (m_en ? m_val : ~m_val);
  always #5 ref_clk = ~ref_clk;

  pmt_table_read #(.UPPER_MASK(MASK)) pmt_table_read_inst (
    .ref_clk(ref_clk), .reset_n(reset_n), .pc_next(pc_next), .fetch_addr(fetch_addr),
    .fetch_word(fetch_word), .instr_phase(instr_phase), .ptr_lo_wr(ptr_lo_wr), .ptr_hi_wr(ptr_hi_wr),
    .ptr_wdata(ptr_wdata), .table_req(table_req), .table_last_page(table_last_page),
    .table_dest(table_dest), .table_busy(table_busy), .dm_wr_en(dm_wr_en), .dm_wr_addr(dm_wr_addr),
    .dm_wr_data(dm_wr_data), .table_upper_byte_latch(table_upper_byte_latch),
    .in_circuit_programming(in_circuit_programming), .on_chip_debug(on_chip_debug),
    .prog_serial_clock(sclk), .prog_serial_data_i(sd_pin), .prog_serial_data_o(sd_o),
    .prog_serial_data_oe(sd_oe), .gpio_a0_out(1'b1), .gpio_a0_oe(1'b1), .gpio_a2_out(1'b1),
    .gpio_a2_oe(1'b1), .gpio_a0_in(a0_in), .gpio_a2_in(a2_in), .port_a_bit_zero_o(a0_o),
    .port_a_bit_zero_oe(a0_oe), .port_a_bit_two_o(a2_o), .port_a_bit_two_oe(a2_oe));

  pmt_tool_model pmt_tool_model_inst (
    .sclk(sclk), .sd_en(m_en), .sd_val(m_val), .sd_pin(sd_pin), .sd_oe(sd_oe));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string m);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, m, seen, exp);
    end
  endtask

  task automatic test_done;
    if (fail_count == 0 && n_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic ptr_wr(input logic hi, input logic [7:0] d);
    @(negedge ref_clk);
    ptr_lo_wr = !hi;
    ptr_hi_wr = hi;
    ptr_wdata = d;
    @(negedge ref_clk);
    ptr_lo_wr = 1'b0;
    ptr_hi_wr = 1'b0;
  endtask

  // the pins must carry only the link while a mode pin is high
  task automatic link(input logic dbg, input logic rd, input logic [10:0] a, input logic [15:0] wd);
    in_circuit_programming = !dbg;
    on_chip_debug = dbg;
    repeat (4) @(negedge ref_clk);
    check(a0_oe, 1'b0, "pin a0 driven in link mode");
    check(a2_oe, 1'b0, "pin a2 driven in link mode");
    check({a0_o, a2_o, a0_in, a2_in}, 4'h0, "port functions in link mode");
    pmt_tool_model_inst.frame(rd, a, wd, rq);
    repeat (8) @(negedge ref_clk);
    in_circuit_programming = 1'b0;
    on_chip_debug = 1'b0;
    repeat (4) @(negedge ref_clk);
  endtask

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    check(fetch_addr, 11'h000, "fetch after reset");
    while (instr_phase !== 2'b00) @(negedge ref_clk);
    @(negedge ref_clk);
    check(instr_phase, 2'b01, "phase T2");
    @(negedge ref_clk);
    check(instr_phase, 2'b11, "phase T3");
    @(negedge ref_clk);
    check(instr_phase, 2'b10, "phase T4");
    check({a0_oe, a0_o}, 2'b11, "pin a0 owned by port");
    check({a0_in, a2_in}, 2'b10, "pin inputs owned by port");
  endtask

  task automatic t_link;
    link(1'b0, 1'b0, 11'h123, 16'hab5a);
    link(1'b1, 1'b0, 11'h706, 16'h1a3c);
    link(1'b1, 1'b1, 11'h123, 16'h0000);
    check(rq, 16'hab5a, "debug read back");
    link(1'b0, 1'b1, 11'h706, 16'h0000);
    check(rq, 16'h1a3c, "link read back");
  endtask

  task automatic t_table(input logic lp, input logic [7:0] hi, input logic [7:0] lo, input logic [15:0] w);
    ptr_wr(1'b0, lo);
    ptr_wr(1'b1, hi);
    while (instr_phase !== 2'b00 || table_busy !== 1'b0) @(negedge ref_clk);
    table_req = 1'b1;
    table_last_page = lp;
    table_dest = lo ^ 8'h80;
    @(negedge ref_clk);
    table_req = 1'b0;
    check(table_busy, 1'b1, "busy after take");
    for (int k = 1; k < 8; k++) begin
      @(negedge ref_clk);
      check(dm_wr_en, 1'b0, "table write early");
    end
    @(negedge ref_clk);
    check(dm_wr_en, 1'b1, "table write at cycle 8");
    check(dm_wr_addr, lo ^ 8'h80, "destination");
    check(dm_wr_data, w[7:0], "low byte");
    check(table_upper_byte_latch, w[15:8] & MASK, "upper byte");
    ptr_wr(1'b0, 8'h00);
    check(table_upper_byte_latch, w[15:8] & MASK, "latch held");
  endtask

  task automatic t_fetch;
    pc_next = 11'h706;
    for (int k = 0; k < 8 && fetch_addr !== 11'h706; k++) @(negedge ref_clk);
    check(fetch_addr, 11'h706, "fetch address");
    @(negedge ref_clk);
    check(fetch_word, 16'h1a3c, "fetch word");
  endtask

  initial begin
    repeat (2) @(posedge ref_clk);
    @(negedge ref_clk);
    reset_n = 1'b1;
    t_reset();
    t_link();
    t_table(1'b0, 8'h01, 8'h23, 16'hab5a);
    t_table(1'b1, 8'h05, 8'h06, 16'h1a3c);
    t_fetch();
    test_done();
  end

  // watchdog: four frames of about 2 us plus table reads need well under this
  initial begin
    #100000;
    fail_count++;
    test_done();
  end
endmodule
